// [rtl/twrc_pkg.sv]
package twrc_pkg;

  // Terminal control mode selector width and the mode this block serves
  localparam int unsigned TWRC_MODE_W      = 3;
  localparam logic [2:0]  TWRC_MODE_3WIRE1 = 3'h2;

  // Reset values of the run outputs and of the edge finder's last sample
  localparam logic        TWRC_RUN_RST     = 1'h0;
  localparam logic        TWRC_DIR_RST     = 1'h0;
  localparam logic        TWRC_PREV_RST    = 1'h0;

  // Direction encoding: closed direction select means reverse
  localparam logic        TWRC_DIR_FWD     = 1'h0;
  localparam logic        TWRC_DIR_REV     = 1'h1;

  // Run state of the decoder
  typedef enum logic [1:0] {
    TWRC_STOPPED,
    TWRC_RUNNING
  } twrc_state_t;

endpackage

// [rtl/twrc_edge.sv]
module twrc_edge
  import twrc_pkg::*;
(
  input  wire logic i_core_clk,
  input  wire logic i_rst_b,
  input  wire logic i_level,
  output wire logic o_rise
);

  logic prev;

  // Last sample; held low at reset so a contact already closed counts as an edge at release
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev <= TWRC_PREV_RST;
    end else begin
      prev <= i_level;
    end
  end

  // Rising edge seen this cycle
  assign o_rise = i_level & ~prev;

endmodule

// [rtl/twrc_run_ctrl.sv]
module twrc_run_ctrl
  import twrc_pkg::*;
(
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst_b,
  input  wire logic [TWRC_MODE_W-1:0] i_terminal_mode,
  input  wire logic                   i_enable_hold_input,
  input  wire logic                   i_start_pulse_input,
  input  wire logic                   i_direction_select_input,
  output logic                        o_run,
  output logic                        o_dir_reverse,
  output wire logic                   o_start_ignored
);

  // Behaviour notes
  // - Contacts arrive already synchronised to the core clock
  // - No debounce here; a bouncing pushbutton needs filtering upstream
  // - A start edge is a low sample followed by a high one
  // - Start held high through reset counts as an edge at release
  // - Direction is sampled only on the starting edge, then frozen
  // - Direction changes while running are not handled; stop and restart
  // - Leaving the mode stops and blocks the drive like an open enable contact, but raises no ignored flag
  // - Start edges while running are dropped, not queued
  // - Stop has priority: an open contact beats a start in the same cycle
  // - Starts ignored for an open enable contact in the mode raise a one-cycle flag for the operator panel
  // - Run and direction outputs are registered, so run follows the edge by one cycle
  // - Direction output keeps its last value while stopped
  // - Reset clears run and direction at once, without waiting for the clock

  twrc_state_t state;
  twrc_state_t next_state;
  logic        next_dir;
  logic        start_rise;

  // Edge finder on the start pulse input only
  twrc_edge u_start_edge (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_level    (i_start_pulse_input),
    .o_rise     (start_rise)
  );

  // Mode decode, shared by the gate below and the checks at the foot
  function automatic logic twrc_is_run_mode(input logic [TWRC_MODE_W-1:0] mode);
    return (mode == TWRC_MODE_3WIRE1);
  endfunction

  // Decode; leaving the mode drops running like an open enable contact
  wire mode_ok  = twrc_is_run_mode(i_terminal_mode);
  wire enabled  = mode_ok & i_enable_hold_input;
  wire start_go = enabled & start_rise;
  assign o_start_ignored = mode_ok & start_rise & ~i_enable_hold_input;
  wire start_dir = i_direction_select_input ? TWRC_DIR_REV : TWRC_DIR_FWD;

  // Next state; direction input alone never starts the drive
  always_comb begin
    next_state = state;
    next_dir   = o_dir_reverse;
    case (state)
      TWRC_STOPPED: begin
        if (start_go) begin
          next_state = TWRC_RUNNING;
          next_dir   = start_dir;
        end
      end
      TWRC_RUNNING: begin
        if (!enabled) begin
          next_state = TWRC_STOPPED;
        end
      end
      default: begin
        next_state = TWRC_STOPPED;
      end
    endcase
  end

  // State and registered outputs
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state         <= TWRC_STOPPED;
      o_run         <= TWRC_RUN_RST;
      o_dir_reverse <= TWRC_DIR_RST;
    end else begin
      state         <= next_state;
      o_run         <= (next_state == TWRC_RUNNING);
      o_dir_reverse <= next_dir;
    end
  end

  // Start edge with enable closed runs on the next edge
  start_runs_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (!o_run && start_go) |=> o_run)
    else $error("start edge did not start run");

  // Direction taken from the select level at start
  dir_latch_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (!o_run && start_go) |=> (o_dir_reverse == $past(i_direction_select_input)))
    else $error("start direction wrong");

  // Open enable stops the drive
  open_stops_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    !i_enable_hold_input |=> !o_run)
    else $error("run survived open enable");

  // Edges while open are ignored
  open_ignore_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (!o_run && !i_enable_hold_input) |=> !o_run)
    else $error("started while open");

  // Run needs mode 2
  mode_gate_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    !twrc_is_run_mode(i_terminal_mode) |=> !o_run)
    else $error("run outside mode");

  // Run only rises after a start edge
  run_cause_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    $rose(o_run) |-> $past(start_rise))
    else $error("run without start edge");

  // Direction frozen while running
  dir_hold_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (o_run && $past(o_run)) |-> $stable(o_dir_reverse))
    else $error("direction moved");

  // Closed contact in the mode keeps the drive running
  run_stay_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (o_run && i_enable_hold_input && twrc_is_run_mode(i_terminal_mode)) |=> o_run)
    else $error("run dropped with enable closed");

  // Opening the contact while running gives one falling edge of run
  stop_fall_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (o_run && !i_enable_hold_input) |=> $fell(o_run))
    else $error("open contact did not stop run");

  // Running implies the contact was closed at the previous edge
  run_enable_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    o_run |-> $past(i_enable_hold_input))
    else $error("run with enable open");

  // Leaving the mode while running stops the drive
  mode_leave_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (o_run && !twrc_is_run_mode(i_terminal_mode)) |=> $fell(o_run))
    else $error("run kept outside mode");

  // Start edge outside the mode never starts
  start_mode_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (!o_run && start_rise && !twrc_is_run_mode(i_terminal_mode)) |=> !o_run)
    else $error("start accepted outside mode");

  // Direction input alone never starts the drive
  dir_only_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (!o_run && !i_start_pulse_input) |=> !o_run)
    else $error("run without start input");

  // Nothing but an accepted start leaves the stopped state
  no_start_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (!o_run && !start_go) |=> !o_run)
    else $error("run without accepted start");

  // A rising run saw start high and enable closed one edge before
  run_edge_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    $rose(o_run) |-> ($past(i_start_pulse_input) && $past(i_enable_hold_input)))
    else $error("run rose without start and enable");

  // Open direction select starts forward
  start_fwd_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (!o_run && start_go && !i_direction_select_input) |=> (o_dir_reverse == TWRC_DIR_FWD))
    else $error("forward start gave reverse");

  // Closed direction select starts reverse
  start_rev_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (!o_run && start_go && i_direction_select_input) |=> (o_dir_reverse == TWRC_DIR_REV))
    else $error("reverse start gave forward");

  // Direction moves only on an accepted start
  dir_idle_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    !(!o_run && start_go) |=> $stable(o_dir_reverse))
    else $error("direction moved without start");

  // A second start edge while running changes nothing
  start_once_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (o_run && start_rise && i_enable_hold_input && twrc_is_run_mode(i_terminal_mode))
      |=> (o_run && $stable(o_dir_reverse)))
    else $error("start while running disturbed run");

  // A flagged start leaves the drive stopped
  ignored_stays_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (o_start_ignored && !o_run) |=> !o_run)
    else $error("ignored start ran the drive");

  // The ignored flag lasts one cycle per edge
  ignore_pulse_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    o_start_ignored |=> !o_start_ignored)
    else $error("ignored flag stuck high");

  // No ignored flag without a start input high
  ignore_edge_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    !i_start_pulse_input |-> !o_start_ignored)
    else $error("ignored flag without start");

endmodule

// [tb/twrc_operator.sv]
module twrc_operator (
  input  wire logic i_core_clk,
  input  wire logic i_want_run,
  input  wire logic i_want_rev,
  input  wire logic i_press,
  output logic      o_enable_hold = 1'b0,
  output logic      o_start = 1'b0,
  output logic      o_direction = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  // Contacts follow the operator one clock late, as a slow station would
  always @(posedge i_core_clk) begin
    o_enable_hold <= i_want_run;
    o_start <= i_press;
    o_direction <= i_want_rev;
  end
endmodule

// [tb/three_wire_run_control_tb.sv]
module three_wire_run_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import twrc_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, want_run = 1'b0, want_rev = 1'b0, press = 1'b0;
  logic [TWRC_MODE_W-1:0] mode = 3'h2;
  logic en, st, dr, run, direction_select_input, ign;
  int failures = 0, samples_checked = 0;
  // Rows: mode, enable, direction, press, then expected run and reverse
  logic [7:0] rows [7] = '{8'h5f, 8'h49, 8'h45, 8'h56, 8'h5e, 8'hbc, 8'h50};
  twrc_operator op (.i_core_clk(clk), .i_want_run(want_run), .i_want_rev(want_rev), .i_press(press),
    .o_enable_hold(en), .o_start(st), .o_direction(dr));
  twrc_run_ctrl dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_terminal_mode(mode), .i_enable_hold_input(en),
    .i_start_pulse_input(st), .i_direction_select_input(dr), .o_run(run), .o_dir_reverse(direction_select_input),
    .o_start_ignored(ign));
  // 40 MHz clock
  initial forever #12.5 clk = ~clk;
  task automatic chk(input string name, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Press is released between rows so every start is a fresh edge
  initial begin
    repeat (10) @(posedge clk);
    chk("run_rst", TWRC_RUN_RST, run);
    chk("dir_rst", TWRC_DIR_RST, direction_select_input);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      @(posedge clk);
      {mode, want_run, want_rev, press} <= rows[i][7:2];
      repeat (3) @(posedge clk);
      #1 chk("run", rows[i][1], run);
      chk("dir", rows[i][0], direction_select_input);
      @(posedge clk);
      press <= 1'b0;
      repeat (2) @(posedge clk);
    end
    // Start edge with the contact open only flags, never runs
    {want_run, press} <= 2'h1;
    @(posedge clk);
    #1 chk("ignored", 1'b1, ign);
    @(posedge clk);
    {want_run, want_rev, press} <= 3'h6;
    repeat (2) @(posedge clk);
    press <= 1'b1;
    #1 chk("still_stopped", 1'b0, run);
    // Bounded wait; a start that never comes shows as a mismatch
    for (int n = 0; n < 5 && run !== 1'b1; n++) @(posedge clk);
    #1 chk("restart", 1'b1, run);
    chk("restart_dir", 1'b1, direction_select_input);
    // Reset in mid-run drops run at once; no false start after release
    @(posedge clk);
    {rst_b, press} <= 2'h0;
    repeat (2) @(posedge clk);
    #1 chk("run_mid_rst", TWRC_RUN_RST, run);
    chk("dir_mid_rst", TWRC_DIR_RST, direction_select_input);
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("no_start_after_rst", 1'b0, run);
    summarize();
  end
endmodule
